//--- lsi_pkg.sv
// lsi_pkg: shared constants for the light sensor interrupt select block.
// assumes a 125 MHz core clock and byte-wide register access from the serial slave.
package lsi_pkg;
    // register offsets as seen by the serial bus slave, plus the source reset value and the read-zero value
    localparam logic [7:0] LSI_SRC_ADDR = 8'h03;
    localparam logic [7:0] LSI_ID_ADDR = 8'h04;
    localparam logic [7:0] LSI_SRC_RESET = 8'h00;
    localparam logic [7:0] LSI_READ_ZERO = 8'h00;
    // channel select codes
    localparam logic [1:0] LSI_SRC_GREEN = 2'h0;
    localparam logic [1:0] LSI_SRC_RED = 2'h1;
    localparam logic [1:0] LSI_SRC_BLUE = 2'h2;
    localparam logic [1:0] LSI_SRC_CLEAR = 2'h3;
    // out-of-range filter codes
    localparam logic [2:0] LSI_FLT_EVERY = 3'h0;
    localparam logic [2:0] LSI_FLT_SINGLE = 3'h1;
    localparam logic [2:0] LSI_FLT_TENTH = 3'h2;
    localparam logic [2:0] LSI_FLT_ONE_SEC = 3'h3;
    // filter durations in ms, converted to core clock cycles
    localparam int LSI_CLK_KHZ = 125000;
    localparam int LSI_TENTH_MS = 100;
    localparam int LSI_ONE_SEC_MS = 1000;
    localparam int LSI_TENTH_CYC = LSI_TENTH_MS * LSI_CLK_KHZ;
    localparam int LSI_ONE_SEC_CYC = LSI_ONE_SEC_MS * LSI_CLK_KHZ;
    localparam int LSI_CNT_W = 27;
    localparam int LSI_RESULT_W = 16;
    // identification fields, values arbitrary
    localparam logic [3:0] LSI_PART_CODE = 4'hA;
    localparam logic [3:0] LSI_SILICON_REVISION = 4'h5;
    // filter streak state, gray along wait -> run
    typedef enum logic [1:0] {
        LSI_ST_WAIT = 2'b00,
        LSI_ST_RUN = 2'b01
    } lsi_state_e;
endpackage

//--- lsi_out_of_range_filter_filter.sv
// lsi_out_of_range_filter_filter: qualifies out-of-range results into interrupt events.
// assumes sample_valid is a one-cycle pulse per converter cycle on core_clk.
`timescale 1ns/1ps
module lsi_out_of_range_filter_filter import lsi_pkg::*; #(
    parameter int TENTH_CYCLES = LSI_TENTH_CYC,
    parameter int ONE_SEC_CYCLES = LSI_ONE_SEC_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // qualified sample
    input wire logic sample_valid,
    input wire logic out_of_range,
    input wire logic [2:0] out_of_range_filter,
    // event out
    output logic irq_event
);
    lsi_state_e state; // streak tracking
    lsi_state_e next_state;
    logic [LSI_CNT_W-1:0] cnt; // cycles since streak start or last event
    logic [LSI_CNT_W-1:0] next_cnt;
    logic next_irq;
    logic [LSI_CNT_W-1:0] limit; // last count before a timed event

    // timed codes pick their window, others need none
    always_comb begin
        limit = '0;
        if (out_of_range_filter == LSI_FLT_TENTH) begin
            limit = LSI_CNT_W'(TENTH_CYCLES - 1);
        end else if (out_of_range_filter == LSI_FLT_ONE_SEC) begin
            limit = LSI_CNT_W'(ONE_SEC_CYCLES - 1);
        end
    end

    // next state of the streak counter and event
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_irq = 1'b0;
        // saturate so a very long streak never wraps
        if (state == LSI_ST_RUN && cnt != '1) begin
            next_cnt = cnt + 1'b1;
        end
        if (sample_valid) begin
            case (out_of_range_filter)
                LSI_FLT_EVERY: begin
                    next_irq = 1'b1; // every converter cycle
                    next_state = LSI_ST_WAIT;
                    next_cnt = '0;
                end
                LSI_FLT_TENTH, LSI_FLT_ONE_SEC: begin
                    if (!out_of_range) begin
                        next_state = LSI_ST_WAIT; // back in window restarts
                        next_cnt = '0;
                    end else if (state == LSI_ST_WAIT) begin
                        next_state = LSI_ST_RUN; // streak begins
                        next_cnt = '0;
                    end else if (cnt >= limit) begin
                        next_irq = 1'b1; // window elapsed
                        next_cnt = '0; // rate-limit: next event needs a full window
                    end
                end
                default: begin
                    // undefined codes act as single, the least surprising choice
                    next_irq = out_of_range;
                    next_state = LSI_ST_WAIT;
                    next_cnt = '0;
                end
            endcase
        end
    end

    // register the filter state
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= LSI_ST_WAIT;
            cnt <= '0;
            irq_event <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            irq_event <= next_irq;
        end
    end

    sequence s_in_range;
        sample_valid && !out_of_range && out_of_range_filter != LSI_FLT_EVERY;
    endsequence

    property p_every;
        @(posedge core_clk) disable iff (!resetn)
        sample_valid && out_of_range_filter == LSI_FLT_EVERY |=> irq_event;
    endproperty
    a_every: assert property (p_every) else $error("every-cycle mode missed an event");

    property p_restart;
        @(posedge core_clk) disable iff (!resetn)
        s_in_range |=> !irq_event && state == LSI_ST_WAIT && cnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("in-range result did not restart count");

    property p_timed;
        @(posedge core_clk) disable iff (!resetn)
        irq_event && $past(state) == LSI_ST_RUN |-> $past(cnt) >= $past(limit)
            && ($past(out_of_range) || $past(out_of_range_filter) == LSI_FLT_EVERY);
    endproperty
    a_timed: assert property (p_timed) else $error("timed event before window elapsed");
endmodule

//--- lsi_int_select.sv
// lsi_int_select: channel select, identification and interrupt qualification.
// assumes register accesses arrive from the serial slave on core_clk and converter
// results arrive on core_clk with a one-cycle result_valid pulse.
//
// Notes on behaviour
// - filter code sets event rate per mode
// - exactly one channel feeds the comparison
// - source field selects green, red, blue, clear
// - identification register ignores writes, never changes
// - identification holds part code and revision
// - out of range: at/below low, above high
// - filter sits ahead of interrupt assertion
`timescale 1ns/1ps
module lsi_int_select import lsi_pkg::*; #(
    parameter int TENTH_CYCLES = LSI_TENTH_CYC,
    parameter int ONE_SEC_CYCLES = LSI_ONE_SEC_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register access from the serial slave
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // converter results
    input wire logic result_valid,
    input wire logic [LSI_RESULT_W-1:0] green_result,
    input wire logic [LSI_RESULT_W-1:0] red_result,
    input wire logic [LSI_RESULT_W-1:0] blue_result,
    input wire logic [LSI_RESULT_W-1:0] clear_result,
    // thresholds and filter setting from neighbouring registers
    input wire logic [LSI_RESULT_W-1:0] low_threshold,
    input wire logic [LSI_RESULT_W-1:0] high_threshold,
    input wire logic [2:0] out_of_range_filter,
    // qualified event
    output logic int_event
);
    logic [1:0] src_sel; // source field, reserved bits not stored
    logic [1:0] next_src_sel;
    logic [7:0] next_rdata;
    logic [LSI_RESULT_W-1:0] sel_result; // compared channel
    logic out_of_range;

    // one channel only; a 2-bit code cannot name two at once
    function automatic logic [LSI_RESULT_W-1:0] pick_channel(input logic [1:0] code,
            input logic [LSI_RESULT_W-1:0] g, input logic [LSI_RESULT_W-1:0] r,
            input logic [LSI_RESULT_W-1:0] b, input logic [LSI_RESULT_W-1:0] c);
        case (code)
            LSI_SRC_GREEN: pick_channel = g;
            LSI_SRC_RED: pick_channel = r;
            LSI_SRC_BLUE: pick_channel = b;
            default: pick_channel = c;
        endcase
    endfunction

    // read data per offset; unmapped reads zero
    function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [1:0] src);
        case (addr)
            LSI_SRC_ADDR: read_value = {6'h00, src};
            LSI_ID_ADDR: read_value = {LSI_PART_CODE, LSI_SILICON_REVISION};
            default: read_value = LSI_READ_ZERO;
        endcase
    endfunction

    // register next values
    always_comb begin
        next_src_sel = src_sel;
        next_rdata = reg_rdata;
        // reserved upper bits are dropped, relying on the host writing zeros
        if (reg_wr && reg_addr == LSI_SRC_ADDR) begin
            next_src_sel = reg_wdata[1:0];
        end
        // writes to the identification offset fall through: nothing stored
        if (reg_rd) begin
            next_rdata = read_value(reg_addr, src_sel);
        end
    end

    // register state
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            src_sel <= LSI_SRC_RESET[1:0];
            reg_rdata <= LSI_READ_ZERO;
        end else begin
            src_sel <= next_src_sel;
            reg_rdata <= next_rdata;
        end
    end

    // comparison on the selected channel; thresholds assumed set for it
    always_comb begin
        sel_result = pick_channel(src_sel, green_result, red_result, blue_result, clear_result);
        out_of_range = (sel_result <= low_threshold) || (sel_result > high_threshold);
    end

    // persistence filter ahead of the interrupt
    lsi_out_of_range_filter_filter #(
        .TENTH_CYCLES(TENTH_CYCLES),
        .ONE_SEC_CYCLES(ONE_SEC_CYCLES)
    ) u_filter (
        .core_clk(core_clk),
        .resetn(resetn),
        .sample_valid(result_valid),
        .out_of_range(out_of_range),
        .out_of_range_filter(out_of_range_filter),
        .irq_event(int_event)
    );

    property p_src_write;
        @(posedge core_clk) disable iff (!resetn)
        reg_wr && reg_addr == LSI_SRC_ADDR && !reg_rd ##1 reg_rd && reg_addr == LSI_SRC_ADDR
            |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2) && reg_rdata[7:2] == 6'h00;
    endproperty
    a_src_write: assert property (p_src_write) else $error("source field readback wrong");

    property p_id_read;
        @(posedge core_clk) disable iff (!resetn)
        reg_rd && reg_addr == LSI_ID_ADDR |=> reg_rdata == {LSI_PART_CODE, LSI_SILICON_REVISION};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification value wrong");

    property p_id_write;
        @(posedge core_clk) disable iff (!resetn)
        reg_wr && reg_addr == LSI_ID_ADDR |=> src_sel == $past(src_sel);
    endproperty
    a_id_write: assert property (p_id_write) else $error("identification write changed state");

    property p_clear_src;
        @(posedge core_clk) disable iff (!resetn)
        result_valid && src_sel == LSI_SRC_CLEAR && out_of_range_filter == LSI_FLT_SINGLE
            && clear_result > high_threshold |=> int_event;
    endproperty
    a_clear_src: assert property (p_clear_src) else $error("selected clear channel missed");

    property p_low_edge;
        @(posedge core_clk) disable iff (!resetn)
        result_valid && out_of_range_filter == LSI_FLT_SINGLE && sel_result == low_threshold
            |=> int_event;
    endproperty
    a_low_edge: assert property (p_low_edge) else $error("result equal to low threshold missed");

    // named steps of the register exchanges checked below
    sequence s_id_written;
        reg_wr && reg_addr == LSI_ID_ADDR;
    endsequence

    sequence s_id_read;
        reg_rd && reg_addr == LSI_ID_ADDR;
    endsequence

    sequence s_src_read;
        reg_rd && reg_addr == LSI_SRC_ADDR;
    endsequence

    sequence s_no_read;
        !reg_rd;
    endsequence

    // a write to the identification offset must not leak into the next read
    property p_id_after_write;
        @(posedge core_clk) disable iff (!resetn)
        s_id_written ##1 s_id_read |=> reg_rdata == {LSI_PART_CODE, LSI_SILICON_REVISION};
    endproperty
    a_id_after_write: assert property (p_id_after_write) else $error("identification changed by write");

    // identification read data stands while no other read is taken
    property p_id_stands;
        @(posedge core_clk) disable iff (!resetn)
        s_id_read ##1 s_no_read |=> reg_rdata == {LSI_PART_CODE, LSI_SILICON_REVISION};
    endproperty
    a_id_stands: assert property (p_id_stands) else $error("identification read data did not hold");

    // source readback is the stored code with zero reserved bits
    property p_src_read;
        @(posedge core_clk) disable iff (!resetn)
        s_src_read |=> reg_rdata == {6'h00, $past(src_sel)};
    endproperty
    a_src_read: assert property (p_src_read) else $error("source readback mismatch");

    // each code routes its own channel into the comparison
    property p_green_route;
        @(posedge core_clk) disable iff (!resetn)
        result_valid && out_of_range_filter == LSI_FLT_SINGLE && src_sel == LSI_SRC_GREEN
            && (green_result <= low_threshold || green_result > high_threshold) |=> int_event;
    endproperty
    a_green_route: assert property (p_green_route) else $error("selected green channel missed");

    // red code: only the red result decides
    property p_red_route;
        @(posedge core_clk) disable iff (!resetn)
        result_valid && out_of_range_filter == LSI_FLT_SINGLE && src_sel == LSI_SRC_RED
            && (red_result <= low_threshold || red_result > high_threshold) |=> int_event;
    endproperty
    a_red_route: assert property (p_red_route) else $error("selected red channel missed");

    // blue code: only the blue result decides
    property p_blue_route;
        @(posedge core_clk) disable iff (!resetn)
        result_valid && out_of_range_filter == LSI_FLT_SINGLE && src_sel == LSI_SRC_BLUE
            && (blue_result <= low_threshold || blue_result > high_threshold) |=> int_event;
    endproperty
    a_blue_route: assert property (p_blue_route) else $error("selected blue channel missed");

    // a result inside the window gives no event in single mode
    property p_in_window;
        @(posedge core_clk) disable iff (!resetn)
        result_valid && out_of_range_filter == LSI_FLT_SINGLE && sel_result > low_threshold
            && sel_result <= high_threshold |=> !int_event;
    endproperty
    a_in_window: assert property (p_in_window) else $error("event raised for in-window result");

    // synchronous reset leaves source green, read data zero and no event
    property p_reset_values;
        @(posedge core_clk)
        !resetn |=> src_sel == LSI_SRC_GREEN && reg_rdata == LSI_READ_ZERO && !int_event;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    // only a write to the source offset may move the selection
    property p_src_keep;
        @(posedge core_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == LSI_SRC_ADDR) |=> $stable(src_sel);
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("selection moved without a write");
endmodule

//--- lsi_host_model.sv
// lsi_host_model: host side of the register port, single byte reads and writes.
// assumes the serial slave already turns bus frames into one-cycle strobes on core_clk.
`timescale 1ns/1ps
module lsi_host_model import lsi_pkg::*; (
    // clock
    input wire logic core_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one write strobe; lines flip after release so stale data never looks valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= (addr == LSI_SRC_ADDR) ? (data & 8'h03) : data; // reserved bits sent as zero
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    // write then read the same offset on the next edge; back to back is legal
    task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rdata);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= (addr == LSI_SRC_ADDR) ? (data & 8'h03) : data; // reserved bits sent as zero
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
        #1;
        rdata = reg_rdata;
    endtask

    // one read strobe; data is registered, so it is taken just after the taking edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask
endmodule

//--- light_sensor_interrupt_select_tb.sv
// light_sensor_interrupt_select_tb: register and event checks of lsi_int_select.
// assumes short filter windows (20 and 50 cycles) set through parameters.
`timescale 1ns/1ps
module light_sensor_interrupt_select_tb import lsi_pkg::*;;
    localparam int TENTH = 20; // shortened windows keep the run brief
    localparam int ONE_SEC = 50;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd, int_event;
    logic result_valid = 1'b0;
    logic [15:0] res [4]; // green, red, blue, clear
    logic [15:0] low_threshold = 16'h0064; // window suits whichever channel is chosen
    logic [15:0] high_threshold = 16'h00C8;
    logic [2:0] out_of_range_filter = 3'h1;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    // clock
    always #4 core_clk = ~core_clk;

    lsi_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    lsi_int_select #(.TENTH_CYCLES(TENTH), .ONE_SEC_CYCLES(ONE_SEC)) dut_u (.core_clk(core_clk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .result_valid(result_valid), .green_result(res[0]), .red_result(res[1]),
        .blue_result(res[2]), .clear_result(res[3]), .low_threshold(low_threshold),
        .high_threshold(high_threshold), .out_of_range_filter(out_of_range_filter), .int_event(int_event));

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // counts and verdict
    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one converter sample: selected channel gets v, the rest o; event looked at next cycle
    task automatic sample(input int sel, input logic [15:0] v, input logic [15:0] o, input logic exp);
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            res[i] <= (i == sel) ? v : o;
        end
        result_valid <= 1'b1;
        @(posedge core_clk);
        result_valid <= 1'b0;
        #1;
        check({7'h00, int_event}, {7'h00, exp});
    endtask

    // streak on green: optional broken streak first, then count cycles to the event
    task automatic timed(input logic [2:0] code, input int pre, input int exp_n);
        @(posedge core_clk);
        out_of_range_filter <= code;
        sample(0, 16'h0096, 16'h0096, 1'b0);
        @(posedge core_clk);
        result_valid <= 1'b1;
        if (pre > 0) begin
            res[0] <= 16'h012C;
            repeat (pre) @(posedge core_clk);
            res[0] <= 16'h0096; // one in-range result mid-streak
            @(posedge core_clk);
        end
        res[0] <= 16'h012C;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            #1;
        end while (int_event !== 1'b1 && n < 200);
        @(posedge core_clk);
        result_valid <= 1'b0;
        // the streak-start edge counts as 1, so the event lands one window later
        check(8'(n), 8'(exp_n + 1));
    endtask

    // hang guard, far above the roughly 190 cycles the sequence needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        for (int i = 0; i < 4; i++) begin
            res[i] = 16'h0096;
        end
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        host_u.rd(LSI_SRC_ADDR, rd_val);
        check(rd_val, LSI_SRC_RESET);
        host_u.rd(LSI_ID_ADDR, rd_val);
        check(rd_val, {LSI_PART_CODE, LSI_SILICON_REVISION});
        host_u.wr_rd(LSI_ID_ADDR, 8'h5A, rd_val);
        check(rd_val, {LSI_PART_CODE, LSI_SILICON_REVISION});
        host_u.rd(8'h05, rd_val);
        check(rd_val, LSI_READ_ZERO);
        // each source code: only its own channel may trigger
        for (int s = 0; s < 4; s++) begin
            host_u.wr_rd(LSI_SRC_ADDR, 8'(s), rd_val);
            check(rd_val, 8'(s));
            sample(s, 16'h012C, 16'h0096, 1'b1);
            sample(s, 16'h0096, 16'h012C, 1'b0);
        end
        // window edges on clear
        sample(3, 16'h0064, 16'h0096, 1'b1);
        sample(3, 16'h0065, 16'h0096, 1'b0);
        sample(3, 16'h00C8, 16'h0096, 1'b0);
        sample(3, 16'h00C9, 16'h0096, 1'b1);
        @(posedge core_clk);
        out_of_range_filter <= 3'h5; // undefined codes behave as single
        sample(3, 16'h00C9, 16'h0096, 1'b1);
        sample(3, 16'h0096, 16'h0096, 1'b0);
        @(posedge core_clk);
        out_of_range_filter <= LSI_FLT_EVERY;
        sample(3, 16'h0096, 16'h0096, 1'b1);
        host_u.wr(LSI_SRC_ADDR, 8'h00);
        timed(LSI_FLT_TENTH, 0, TENTH);
        timed(LSI_FLT_TENTH, 10, TENTH);
        timed(LSI_FLT_ONE_SEC, 0, ONE_SEC);
        wrap_up();
    end
endmodule
